// [verilog/sector_protect_map.sv]
// Serial command handling for the nonvolatile sector protection table
`timescale 1ns/100ps

module sector_protect_map #(
    parameter int unsigned erase_cycles = protect_map_pkg::TABLE_ERASE_CYCLES,
    parameter int unsigned program_cycles = protect_map_pkg::PROGRAM_CYCLE_CYCLES
) (
    input wire logic clock,
    input wire logic reset,
    input wire logic serial_clock,
    input wire logic chip_select_n,
    input wire logic serial_in,
    output logic serial_out,
    output logic serial_out_oe,
    input wire logic write_guard_n,
    output logic busy,
    output protect_map_pkg::guard_t guard,
    output logic [7:0] data_buffer [0:protect_map_pkg::TABLE_BYTES-1]
);
    import protect_map_pkg::*;

    // ------------------------------------------------------------
    // Link side: bit and byte framing, reset while chip select is high
    // ------------------------------------------------------------
    logic [6:0] shift_in;
    logic [2:0] bit_pos;
    logic [3:0] byte_count;
    wire logic frame_reset;
    wire logic [7:0] byte_in;
    wire logic byte_done;
    wire logic first_edge;

    assign frame_reset = reset | chip_select_n;
    assign byte_in = {shift_in, serial_in};
    assign byte_done = (bit_pos == 3'h7);
    assign first_edge = (bit_pos == 3'h0) && (byte_count == 4'h0);

    always_ff @(posedge serial_clock or posedge frame_reset) begin
        if (frame_reset) begin
            shift_in <= 7'h00;
            bit_pos <= 3'h0;
            byte_count <= 4'h0;
        end else begin
            shift_in <= byte_in[6:0];
            bit_pos <= bit_pos + 3'h1;
            if (byte_done && byte_count != BYTE_COUNT_MAX) begin
                byte_count <= byte_count + 4'h1;
            end
        end
    end

    // ------------------------------------------------------------
    // Link side: command decode and data buffer
    // These hold past the frame end, when the link clock has stopped,
    // so the clock side may read them after it sees chip select rise.
    // ------------------------------------------------------------
    cmd_t cmd;
    cmd_t next_cmd;
    logic aligned;
    logic [3:0] write_mask;
    logic [1:0] data_ptr;
    wire logic data_phase;

    assign data_phase = byte_count >= OPCODE_BYTES;

    always_comb begin
        next_cmd = cmd;
        if (byte_done) begin
            unique case (byte_count)
                4'h0: begin
                    if (byte_in == OPC_PREFIX_0) begin
                        next_cmd = cmd_prefix;
                    end else if (byte_in == OPC_READ) begin
                        next_cmd = cmd_read;
                    end else begin
                        next_cmd = cmd_none;
                    end
                end
                4'h1: begin
                    if (cmd != cmd_prefix || byte_in != OPC_PREFIX_1) begin
                        next_cmd = (cmd == cmd_read) ? cmd_read : cmd_none;
                    end
                end
                4'h2: begin
                    if (cmd != cmd_prefix || byte_in != OPC_PREFIX_2) begin
                        next_cmd = (cmd == cmd_read) ? cmd_read : cmd_none;
                    end
                end
                4'h3: begin
                    if (cmd == cmd_prefix && byte_in == OPC_ERASE_3) begin
                        next_cmd = cmd_erase;
                    end else if (cmd == cmd_prefix && byte_in == OPC_PROGRAM_3) begin
                        next_cmd = cmd_program;
                    end else if (cmd != cmd_read) begin
                        next_cmd = cmd_none;
                    end
                end
                default: begin
                    if (cmd == cmd_erase) begin
                        next_cmd = cmd_none;
                    end
                end
            endcase
        end
    end

    always_ff @(posedge serial_clock or posedge reset) begin
        if (reset) begin
            cmd <= cmd_none;
            aligned <= 1'b1;
            write_mask <= 4'h0;
            data_ptr <= 2'h0;
        end else begin
            cmd <= next_cmd;
            aligned <= byte_done;
            if (first_edge) begin
                write_mask <= 4'h0;
                data_ptr <= 2'h0;
            end else if (byte_done && data_phase && cmd == cmd_program) begin
                write_mask[data_ptr] <= 1'b1;
                data_ptr <= data_ptr + 2'h1;
            end
        end
    end

    // Program data lands in the shared buffer, replacing only the slots it writes; the rest keep their earlier contents
    always_ff @(posedge serial_clock or posedge reset) begin
        if (reset) begin
            for (int i = 0; i < TABLE_BYTES; i++) begin
                data_buffer[i] <= 8'h00;
            end
        end else if (byte_done && data_phase && cmd == cmd_program) begin
            data_buffer[data_ptr] <= byte_in;
        end
    end

    // ------------------------------------------------------------
    // Link side: table read out, changed on the falling edge
    // ------------------------------------------------------------
    logic [7:0] table_byte [0:TABLE_BYTES-1];
    wire logic read_active;
    wire logic read_in_range;
    wire logic [7:0] read_byte;

    assign read_active = (cmd == cmd_read) && data_phase;
    assign read_in_range = byte_count <= READ_LAST_BYTE;
    assign read_byte = table_byte[byte_count[1:0]];

    always_ff @(negedge serial_clock or posedge frame_reset) begin
        if (frame_reset) begin
            serial_out <= 1'b0;
            serial_out_oe <= 1'b0;
        end else begin
            serial_out_oe <= read_active;
            if (read_active && read_in_range) begin
                serial_out <= read_byte[3'h7 - bit_pos];
            end else begin
                serial_out <= 1'b0;
            end
        end
    end

    // ------------------------------------------------------------
    // Clock side: synchronisers for chip select and write guard
    // ------------------------------------------------------------
    logic cs_meta;
    logic cs_sync;
    logic cs_prev;
    logic guard_meta;
    logic guard_sync_n;
    wire logic frame_end;
    wire logic table_writable;

    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            cs_meta <= 1'b1;
            cs_sync <= 1'b1;
            cs_prev <= 1'b1;
            guard_meta <= 1'b1;
            guard_sync_n <= 1'b1;
        end else begin
            cs_meta <= chip_select_n;
            cs_sync <= cs_meta;
            cs_prev <= cs_sync;
            guard_meta <= write_guard_n;
            guard_sync_n <= guard_meta;
        end
    end

    assign frame_end = cs_sync & ~cs_prev;
    assign table_writable = guard_sync_n;

    // ------------------------------------------------------------
    // Clock side: self-timed erase and program cycles
    // ------------------------------------------------------------
    op_t op;
    logic [TIMER_WIDTH-1:0] timer;
    logic [3:0] pending_mask;
    logic [7:0] pending_byte [0:TABLE_BYTES-1];
    wire logic start_erase;
    wire logic start_program;
    wire logic timer_done;
    wire logic [TIMER_WIDTH-1:0] erase_load;
    wire logic [TIMER_WIDTH-1:0] program_load;

    // Erase and program are taken only while the synchronised write_guard_n is high
    assign start_erase = frame_end && op == op_idle && table_writable && aligned
        && cmd == cmd_erase;
    assign start_program = frame_end && op == op_idle && table_writable && aligned
        && cmd == cmd_program && write_mask != 4'h0;
    assign timer_done = (timer == '0);
    assign erase_load = TIMER_WIDTH'(erase_cycles - 1);
    assign program_load = TIMER_WIDTH'(program_cycles - 1);

    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            op <= op_idle;
            timer <= '0;
            pending_mask <= 4'h0;
        end else begin
            unique case (op)
                op_idle: begin
                    if (start_erase) begin
                        op <= op_erase;
                        timer <= erase_load;
                    end else if (start_program) begin
                        op <= op_program;
                        timer <= program_load;
                        pending_mask <= write_mask;
                    end
                end
                op_erase, op_program: begin
                    if (timer_done) begin
                        op <= op_idle;
                    end else begin
                        timer <= timer - TIMER_WIDTH'(1);
                    end
                end
                default: begin
                    op <= op_idle;
                end
            endcase
        end
    end

    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            for (int i = 0; i < TABLE_BYTES; i++) begin
                pending_byte[i] <= 8'h00;
            end
        end else if (start_program) begin
            pending_byte <= data_buffer;
        end
    end

    // ------------------------------------------------------------
    // Clock side: the table itself, written at the end of a cycle
    // Programming only clears bits, as a flash cell would.
    // ------------------------------------------------------------
    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            for (int i = 0; i < TABLE_BYTES; i++) begin
                table_byte[i] <= FACTORY_VALUE;
            end
        end else if (timer_done && op == op_erase) begin
            for (int i = 0; i < TABLE_BYTES; i++) begin
                table_byte[i] <= BYTE_GUARDED;
            end
        end else if (timer_done && op == op_program) begin
            for (int i = 0; i < TABLE_BYTES; i++) begin
                if (pending_mask[i]) begin
                    table_byte[i] <= table_byte[i] & pending_byte[i];
                end
            end
        end
    end

    // ------------------------------------------------------------
    // Clock side: status and decoded guard settings
    // ------------------------------------------------------------
    guard_t next_guard;

    always_comb begin
        next_guard.guard_0a = &table_byte[0][SECTOR0_PART_A_HI:SECTOR0_PART_A_LO];
        next_guard.guard_0b = &table_byte[0][SECTOR0_PART_B_HI:SECTOR0_PART_B_LO];
        for (int i = 1; i < TABLE_BYTES; i++) begin
            next_guard.guard_sector[i] = (table_byte[i] == BYTE_GUARDED);
        end
    end

    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            busy <= 1'b0;
            guard <= '0;
        end else begin
            // Raised with the start so busy spans the whole cycle count
            busy <= start_erase || start_program || (op != op_idle && !timer_done);
            guard <= next_guard;
        end
    end

endmodule : sector_protect_map

// [verilog/protect_map_pkg.sv]
// Constants, types and timing for the sector protection table command block
package protect_map_pkg;

    // ------------------------------------------------------------
    // Table geometry and encodings
    // ------------------------------------------------------------
    localparam int TABLE_BYTES = 4;
    localparam logic [7:0] BYTE_GUARDED = 8'hff;
    localparam logic [7:0] BYTE_UNGUARDED = 8'h00;
    localparam logic [7:0] FACTORY_VALUE = 8'h00;
    localparam int SECTOR0_PART_A_HI = 7;
    localparam int SECTOR0_PART_A_LO = 6;
    localparam int SECTOR0_PART_B_HI = 5;
    localparam int SECTOR0_PART_B_LO = 4;

    // ------------------------------------------------------------
    // Opcode bytes
    // ------------------------------------------------------------
    localparam logic [7:0] OPC_PREFIX_0 = 8'h3d;
    localparam logic [7:0] OPC_PREFIX_1 = 8'h2a;
    localparam logic [7:0] OPC_PREFIX_2 = 8'h7f;
    localparam logic [7:0] OPC_ERASE_3 = 8'hcf;
    localparam logic [7:0] OPC_PROGRAM_3 = 8'hfc;
    localparam logic [7:0] OPC_READ = 8'h32;
    localparam logic [3:0] OPCODE_BYTES = 4'h4;
    localparam logic [3:0] READ_LAST_BYTE = 4'h7;
    localparam logic [3:0] BYTE_COUNT_MAX = 4'hf;

    // ------------------------------------------------------------
    // Self-timed cycles
    // ------------------------------------------------------------
    localparam int CLOCK_KHZ = 25000;
    localparam int TABLE_ERASE_TIME_US = 3000;
    localparam int PROGRAM_CYCLE_TIME_US = 3000;
    localparam int TABLE_ERASE_CYCLES = TABLE_ERASE_TIME_US * CLOCK_KHZ / 1000;
    localparam int PROGRAM_CYCLE_CYCLES = PROGRAM_CYCLE_TIME_US * CLOCK_KHZ / 1000;
    localparam int TIMER_WIDTH = 24;

    // ------------------------------------------------------------
    // Types
    // ------------------------------------------------------------
    typedef enum logic [2:0] {
        cmd_none,
        cmd_prefix,
        cmd_erase,
        cmd_program,
        cmd_read
    } cmd_t;

    typedef enum logic [1:0] {
        op_idle,
        op_erase,
        op_program
    } op_t;

    typedef struct packed {
        logic guard_0a;
        logic guard_0b;
        logic [3:1] guard_sector;
    } guard_t;

endpackage : protect_map_pkg

// [verif/sector_protect_map_properties.sv]
// Port-level checks for the protection table command block
`timescale 1ns/100ps
module sector_protect_map_properties #(
    parameter int unsigned erase_cycles = 4,
    parameter int unsigned program_cycles = 4
) (
    input wire logic clock,
    input wire logic reset,
    input wire logic serial_clock,
    input wire logic chip_select_n,
    input wire logic serial_in,
    input wire logic serial_out,
    input wire logic serial_out_oe,
    input wire logic write_guard_n,
    input wire logic busy,
    input wire protect_map_pkg::guard_t guard,
    input wire logic [7:0] data_buffer [0:protect_map_pkg::TABLE_BYTES-1]
);
    import protect_map_pkg::*;
    logic [23:0] busy_run;
    logic [31:0] buffer_flat;
    assign buffer_flat = {data_buffer[0], data_buffer[1], data_buffer[2], data_buffer[3]};
    // Length of the current busy run, held until busy falls
    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            busy_run <= 24'h000000;
        end else begin
            busy_run <= busy ? busy_run + 24'h000001 : 24'h000000;
        end
    end
    default clocking @(posedge clock); endclocking
    default disable iff (reset);
    sequence s_busy_hold;
        busy [*4];
    endsequence
    property p_oe_off; chip_select_n |-> !serial_out_oe; endproperty
    property p_oe_frame; $rose(serial_out_oe) |-> !chip_select_n && !$past(chip_select_n); endproperty
    property p_busy_start; $rose(busy) |-> $past(chip_select_n, 1) && $past(chip_select_n, 3); endproperty
    property p_busy_min; $rose(busy) |-> s_busy_hold; endproperty
    property p_busy_len;
        $fell(busy) |-> busy_run == 24'(erase_cycles) || busy_run == 24'(program_cycles);
    endproperty
    property p_guard_block; (!write_guard_n) [*6] |=> !$rose(busy); endproperty
    property p_out_quiet; !serial_out_oe |-> !serial_out; endproperty
    property p_guard_hold;
        !busy && !$past(busy) && !$past(busy, 2) && !$past(busy, 3) |-> $stable(guard);
    endproperty
    property p_buffer_hold; chip_select_n && $past(chip_select_n) |-> $stable(buffer_flat); endproperty
    a_oe_off: assert property (p_oe_off) else $error("output enable high outside frame");
    a_oe_frame: assert property (p_oe_frame) else $error("output enabled without frame");
    a_busy_start: assert property (p_busy_start) else $error("busy rose inside frame");
    a_busy_min: assert property (p_busy_min) else $error("busy run too short");
    a_busy_len: assert property (p_busy_len) else $error("busy run length wrong");
    a_guard_block: assert property (p_guard_block) else $error("op started while guarded");
    a_guard_hold: assert property (p_guard_hold) else $error("guard changed while idle");
    a_buffer_hold: assert property (p_buffer_hold) else $error("buffer changed off frame");
    a_out_quiet: assert property (p_out_quiet) else $error("output high while released");
endmodule : sector_protect_map_properties

bind sector_protect_map sector_protect_map_properties #(
    .erase_cycles(erase_cycles),
    .program_cycles(program_cycles)
) sector_protect_map_properties_i (
    .clock(clock), .reset(reset), .serial_clock(serial_clock),
    .chip_select_n(chip_select_n), .serial_in(serial_in), .serial_out(serial_out),
    .serial_out_oe(serial_out_oe), .write_guard_n(write_guard_n), .busy(busy),
    .guard(guard), .data_buffer(data_buffer)
);

// [verif/host_model.sv]
// Serial bus master model standing in for the host controller
`timescale 1ns/100ps
module host_model (
    output logic serial_clock,
    output logic chip_select_n,
    output logic serial_in,
    input wire logic serial_out,
    input wire logic serial_out_oe
);
    // Link clock idles low and only runs inside frames
    initial begin
        serial_clock = 1'b0;
        chip_select_n = 1'b1;
        serial_in = 1'b0;
    end
    // One byte, MSB first, input and output both taken at the rising edge
    task automatic xfer(input logic [7:0] d, output logic [7:0] q);
        for (int i = 7; i >= 0; i--) begin
            serial_in = d[i];
            #7.5 serial_clock = 1'b1;
            q[i] = serial_out_oe ? serial_out : ~serial_out;
            #7.5 serial_clock = 1'b0;
        end
    endtask : xfer
    // Whole frame of n bytes; data line toggled once released
    task automatic frame(input logic [7:0] tx [0:8], input int n, output logic [7:0] rx [0:8]);
        chip_select_n = 1'b0;
        #7.5;
        for (int k = 0; k < n; k++) xfer(tx[k], rx[k]);
        #7.5 chip_select_n = 1'b1;
        serial_in = ~serial_in;
    endtask : frame
endmodule : host_model

// [verif/testbench.sv]
// Self-checking bench for the protection table command block
`timescale 1ns/100ps
module testbench;
    import protect_map_pkg::*;
    localparam int CYCLES = 4;
    logic clock = 1'b0;
    logic reset = 1'b1;
    logic write_guard_n = 1'b1;
    wire logic serial_clock, chip_select_n, serial_in, serial_out, serial_out_oe, busy;
    guard_t guard;
    logic [7:0] data_buffer [0:TABLE_BYTES-1];
    logic [7:0] tx [0:8];
    logic [7:0] rx [0:8];
    int error_cnt = 0;
    int n_compared = 0;
    int cycles = 0;
    always #20 clock = ~clock;
    sector_protect_map #(.erase_cycles(CYCLES), .program_cycles(CYCLES)) sector_protect_map_i (
        .clock(clock), .reset(reset), .serial_clock(serial_clock),
        .chip_select_n(chip_select_n), .serial_in(serial_in), .serial_out(serial_out),
        .serial_out_oe(serial_out_oe), .write_guard_n(write_guard_n), .busy(busy),
        .guard(guard), .data_buffer(data_buffer)
    );
    host_model host_model_i (
        .serial_clock(serial_clock), .chip_select_n(chip_select_n), .serial_in(serial_in),
        .serial_out(serial_out), .serial_out_oe(serial_out_oe)
    );
    task automatic complete_run;
        $display("compared %0d mismatches %0d", n_compared, error_cnt);
        if (error_cnt == 0 && n_compared > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : complete_run
    task automatic check_byte(input logic [7:0] got, input logic [7:0] exp);
        n_compared++;
        if (got !== exp) begin
            error_cnt++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : check_byte
    task automatic check_bit(input logic got, input logic exp);
        n_compared++;
        if (got !== exp) begin
            error_cnt++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : check_bit
    task automatic send(input int n);
        repeat (4) @(posedge clock);
        #2;
        host_model_i.frame(tx, n, rx);
    endtask : send
    // Measures the busy run that follows a frame; zero when nothing starts
    task automatic wait_op(input int exp_len);
        int len;
        len = 0;
        for (int i = 0; i < 12 && busy !== 1'b1; i++) begin
            @(posedge clock);
            #2;
        end
        while (busy === 1'b1 && len < 200) begin
            @(posedge clock);
            #2;
            len++;
        end
        repeat (4) @(posedge clock);
        #2;
        check_byte(8'(len), 8'(exp_len));
    endtask : wait_op
    task automatic read_table(input logic [31:0] exp);
        tx = '{8'h32, 8'h00, 8'h00, 8'h00, 8'ha5, 8'h5a, 8'ha5, 8'h5a, 8'ha5};
        send(9);
        for (int k = 0; k < 4; k++) check_byte(rx[k + 4], exp[31 - 8 * k -: 8]);
        check_byte(rx[8], 8'h00);
        @(posedge clock);
        #2;
        check_bit(serial_out_oe, 1'b0);
    endtask : read_table
    task automatic erase;
        tx = '{8'h3d, 8'h2a, 8'h7f, 8'hcf, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
        send(4);
    endtask : erase
    always @(posedge clock) begin
        cycles++;
        if (cycles == 4000) begin
            error_cnt++;
            $display("timeout at %0t", $time);
            complete_run;
        end
    end
    initial begin
        repeat (6) @(posedge clock);
        #2;
        reset = 1'b0;
        check_bit(busy, 1'b0);
        check_byte(8'(guard), 8'h00);
        read_table(32'h00000000);
        $display("test reset_state done");
        erase;
        wait_op(CYCLES);
        check_byte(8'(guard), 8'h1f);
        read_table(32'hffffffff);
        $display("test erase done");
        tx = '{8'h3d, 8'h2a, 8'h7f, 8'hfc, 8'hc0, 8'h00, 8'hff, 8'h00, 8'h30};
        send(9);
        wait_op(CYCLES);
        check_byte(8'(guard), 8'h0a);
        for (int k = 0; k < 4; k++) check_byte(data_buffer[k], 8'(32'h3000ff00 >> (24 - 8 * k)));
        read_table(32'h3000ff00);
        $display("test program_wrap done");
        @(posedge clock);
        #2;
        write_guard_n = 1'b0;
        erase;
        wait_op(0);
        write_guard_n = 1'b1;
        tx = '{8'h3d, 8'h2a, 8'h7f, 8'ha9, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
        send(4);
        wait_op(0);
        tx[3] = 8'hcf;
        send(5);
        wait_op(0);
        check_byte(8'(guard), 8'h0a);
        $display("test refused done");
        erase;
        wait_op(CYCLES);
        tx = '{8'h3d, 8'h2a, 8'h7f, 8'hfc, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
        send(8);
        wait_op(CYCLES);
        check_byte(8'(guard), 8'h00);
        $display("test unguard done");
        complete_run;
    end
endmodule : testbench
